// >>> src/irq_regs_consts.vh
// register map, field positions and reset values of the interrupt pending/active block
`ifndef IRQ_REGS_CONSTS_VH
`define IRQ_REGS_CONSTS_VH

// ==========================================================
// register byte addresses
`define ADDR_W 32
`define ENABLE_SET_ADDR 32'he000e100
`define ENABLE_CLEAR_ADDR 32'he000e180
`define PENDING_SET_ADDR 32'he000e200
`define PENDING_CLEAR_ADDR 32'he000e280
`define ACTIVE_STATUS_ADDR 32'he000e300
`define ACK_ADDR 32'he000e380
`define IRQ_STATUS_ADDR 32'he000e400
`define IRQ_CLEAR_ADDR 32'he000e404
`define IRQ_ENABLE_ADDR 32'he000e408

// ==========================================================
// source bit positions
`define SRC_COUNT 17
`define BIT_TIMER_ONE 0
`define BIT_TIMER_TWO 1
`define BIT_MANAGEMENT 2
`define BIT_BASEBAND 3
`define BIT_SLEEP_TIMER 4
`define BIT_SERIAL_ONE 5
`define BIT_SERIAL_TWO 6
`define BIT_CRYPTO 7
`define BIT_RADIO_TIMER 8
`define BIT_RADIO_TX 9
`define BIT_RADIO_RX 10
`define BIT_ADC 11
`define BIT_EXT_PIN_A 12
`define BIT_EXT_PIN_B 13
`define BIT_EXT_PIN_C 14
`define BIT_EXT_PIN_D 15
`define BIT_DEBUG 16

// ==========================================================
// reset values and block event bits
`define SRC_RESET 17'h00000
`define EVT_COUNT 2
`define EVT_NEW_PENDING 0
`define EVT_OVERRUN 1
`define EVT_RESET 2'h0

`endif

// >>> src/w1_bit_cell.v
// one source bit of a write-one-to-set / write-one-to-clear flag, set winning over clear
`timescale 1ns/1ps
`default_nettype none
module w1_bit_cell (
	input wire ref_clk,
	input wire resetn,
	input wire set_pulse,
	input wire clear_pulse,
	output reg flag_reg
);
	wire flag_next;

	// set beats clear when both land together
	assign flag_next = set_pulse ? 1'b1 : (clear_pulse ? 1'b0 : flag_reg);

	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end
endmodule // w1_bit_cell
`default_nettype wire

// >>> src/sticky_irq_bank.v
// sticky status bits with enable mask and one level interrupt output
`timescale 1ns/1ps
`default_nettype none
module sticky_irq_bank #(
	parameter WIDTH = 2
) (
	input wire ref_clk,
	input wire resetn,
	input wire [WIDTH-1:0] event_pulse,
	input wire [WIDTH-1:0] clear_pulse,
	input wire enable_wr,
	input wire [WIDTH-1:0] enable_data,
	output wire [WIDTH-1:0] status,
	output reg [WIDTH-1:0] enable_reg,
	output wire irq
);
	genvar i;

	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_status
			w1_bit_cell u_cell (
				.ref_clk(ref_clk),
				.resetn(resetn),
				.set_pulse(event_pulse[i]),
				.clear_pulse(clear_pulse[i]),
				.flag_reg(status[i])
			);
		end
	endgenerate

	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			enable_reg <= {WIDTH{1'b0}};
		end else if (enable_wr) begin
			enable_reg <= enable_data;
		end
	end

	assign irq = |(status & enable_reg);
endmodule // sticky_irq_bank
`default_nettype wire

// >>> src/irq_pending_active.v
// top-level interrupt pending, enable and active status registers for seventeen sources
//
// How it works
// (R01) pending-set write of one pends source
// (R02) pending-clear write of one unpends source
// (R03) read-only active register, same bit layout
// (R04) bit 16 debug, bits 15..12 pins D..A
// (R05) bit 11 ADC, 10..8 radio rx/tx/timer
// (R06) bit 7 crypto, 6..5 serial, 4 sleep
// (R07) bit 3 baseband, 2 management, 1..0 timers
// (R08) enable set/clear registers, same bit layout
// (R09) pending registers read pending; upper bits zero
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "irq_regs_consts.vh"
`default_nettype none
module irq_pending_active #(
	parameter NSRC = `SRC_COUNT
) (
	input wire ref_clk,
	input wire resetn,
	input wire [`ADDR_W-1:0] addr,
	input wire [31:0] wdata,
	input wire wr_stb,
	input wire rd_stb,
	output reg [31:0] rdata,
	input wire timer_one_src,
	input wire timer_two_src,
	input wire management_src,
	input wire baseband_src,
	input wire sleep_timer_src,
	input wire serial_ctrl_one_src,
	input wire serial_ctrl_two_src,
	input wire crypto_src,
	input wire radio_timer_src,
	input wire radio_tx_src,
	input wire radio_rx_src,
	input wire adc_src,
	input wire ext_pin_a_src,
	input wire ext_pin_b_src,
	input wire ext_pin_c_src,
	input wire ext_pin_d_src,
	input wire debug_src,
	input wire [NSRC-1:0] service_done,
	output reg [NSRC-1:0] pending_out,
	output reg [NSRC-1:0] active_out,
	output wire irq
);
	// ==========================================================
	// source vector
	wire [NSRC-1:0] src_vec;
	wire [NSRC-1:0] src_rise;
	reg [NSRC-1:0] src_prev_reg;

	assign src_vec[`BIT_DEBUG] = debug_src; // [R04]
	assign src_vec[`BIT_EXT_PIN_D] = ext_pin_d_src; // [R04]
	assign src_vec[`BIT_EXT_PIN_C] = ext_pin_c_src; // [R04]
	assign src_vec[`BIT_EXT_PIN_B] = ext_pin_b_src; // [R04]
	assign src_vec[`BIT_EXT_PIN_A] = ext_pin_a_src; // [R04]
	assign src_vec[`BIT_ADC] = adc_src; // [R05]
	assign src_vec[`BIT_RADIO_RX] = radio_rx_src; // [R05]
	assign src_vec[`BIT_RADIO_TX] = radio_tx_src; // [R05]
	assign src_vec[`BIT_RADIO_TIMER] = radio_timer_src; // [R05]
	assign src_vec[`BIT_CRYPTO] = crypto_src; // [R06]
	assign src_vec[`BIT_SERIAL_TWO] = serial_ctrl_two_src; // [R06]
	assign src_vec[`BIT_SERIAL_ONE] = serial_ctrl_one_src; // [R06]
	assign src_vec[`BIT_SLEEP_TIMER] = sleep_timer_src; // [R06]
	assign src_vec[`BIT_BASEBAND] = baseband_src; // [R07]
	assign src_vec[`BIT_MANAGEMENT] = management_src; // [R07]
	assign src_vec[`BIT_TIMER_TWO] = timer_two_src; // [R07]
	assign src_vec[`BIT_TIMER_ONE] = timer_one_src; // [R07]

	// rising edge of a source pends it
	assign src_rise = src_vec & ~src_prev_reg;

	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			src_prev_reg <= `SRC_RESET;
		end else begin
			src_prev_reg <= src_vec;
		end
	end

	// ==========================================================
	// address decode
	wire hit_en_set = (addr == `ENABLE_SET_ADDR);
	wire hit_en_clr = (addr == `ENABLE_CLEAR_ADDR);
	wire hit_pend_set = (addr == `PENDING_SET_ADDR);
	wire hit_pend_clr = (addr == `PENDING_CLEAR_ADDR);
	wire hit_active = (addr == `ACTIVE_STATUS_ADDR);
	wire hit_ack = (addr == `ACK_ADDR);
	wire hit_irq_status = (addr == `IRQ_STATUS_ADDR);
	wire hit_irq_clear = (addr == `IRQ_CLEAR_ADDR);
	wire hit_irq_enable = (addr == `IRQ_ENABLE_ADDR);

	wire [NSRC-1:0] wr_bits = wdata[NSRC-1:0];
	wire [NSRC-1:0] pend_set_wr = (wr_stb && hit_pend_set) ? wr_bits : {NSRC{1'b0}};
	wire [NSRC-1:0] pend_clr_wr = (wr_stb && hit_pend_clr) ? wr_bits : {NSRC{1'b0}};
	wire [NSRC-1:0] en_set_wr = (wr_stb && hit_en_set) ? wr_bits : {NSRC{1'b0}};
	wire [NSRC-1:0] en_clr_wr = (wr_stb && hit_en_clr) ? wr_bits : {NSRC{1'b0}};
	wire [NSRC-1:0] ack_wr = (wr_stb && hit_ack) ? wr_bits : {NSRC{1'b0}};

	// ==========================================================
	// per-source pending, enable and active state
	wire [NSRC-1:0] pending;
	wire [NSRC-1:0] enabled;
	wire [NSRC-1:0] active;
	wire [NSRC-1:0] take;
	wire [NSRC-1:0] retire;
	genvar i;

	// an enabled pending source with nothing in service becomes active
	assign take = pending & enabled & ~active & {NSRC{~(|active)}};
	assign retire = service_done | ack_wr;

	generate
		for (i = 0; i < NSRC; i = i + 1) begin : g_src
			w1_bit_cell u_pending (
				.ref_clk(ref_clk),
				.resetn(resetn),
				.set_pulse(pend_set_wr[i] | src_rise[i]), // [R01]
				.clear_pulse(pend_clr_wr[i] | take[i]), // [R02]
				.flag_reg(pending[i])
			);
			w1_bit_cell u_enable (
				.ref_clk(ref_clk),
				.resetn(resetn),
				.set_pulse(en_set_wr[i]), // [R08]
				.clear_pulse(en_clr_wr[i]), // [R08]
				.flag_reg(enabled[i])
			);
			w1_bit_cell u_active (
				.ref_clk(ref_clk),
				.resetn(resetn),
				.set_pulse(take[i]), // [R03]
				.clear_pulse(retire[i]),
				.flag_reg(active[i])
			);
		end
	endgenerate

	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pending_out <= `SRC_RESET;
			active_out <= `SRC_RESET;
		end else begin
			pending_out <= pending;
			active_out <= active;
		end
	end

	// ==========================================================
	// block events: new pending source, and an edge on an already pending one
	wire [`EVT_COUNT-1:0] evt;
	wire [`EVT_COUNT-1:0] evt_status;
	wire [`EVT_COUNT-1:0] evt_enable;
	wire [`EVT_COUNT-1:0] evt_clear;

	assign evt[`EVT_NEW_PENDING] = |(src_rise & ~pending);
	assign evt[`EVT_OVERRUN] = |(src_rise & pending);
	assign evt_clear = (wr_stb && hit_irq_clear) ? wdata[`EVT_COUNT-1:0] : `EVT_RESET;

	sticky_irq_bank #(
		.WIDTH(`EVT_COUNT)
	) u_irq_bank (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.event_pulse(evt),
		.clear_pulse(evt_clear),
		.enable_wr(wr_stb && hit_irq_enable),
		.enable_data(wdata[`EVT_COUNT-1:0]),
		.status(evt_status),
		.enable_reg(evt_enable),
		.irq(irq)
	);

	// ==========================================================
	// read data, valid the cycle after the read strobe
	reg [31:0] rdata_next;

	always @* begin
		rdata_next = 32'h00000000;
		if (rd_stb) begin
			if (hit_pend_set || hit_pend_clr) begin
				rdata_next[NSRC-1:0] = pending; // [R09]
			end else if (hit_en_set || hit_en_clr) begin
				rdata_next[NSRC-1:0] = enabled; // [R08]
			end else if (hit_active) begin
				rdata_next[NSRC-1:0] = active; // [R03]
			end else if (hit_irq_status) begin
				rdata_next[`EVT_COUNT-1:0] = evt_status;
			end else if (hit_irq_enable) begin
				rdata_next[`EVT_COUNT-1:0] = evt_enable;
			end
		end
	end

	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= 32'h00000000;
		end else begin
			rdata <= rdata_next;
		end
	end
endmodule // irq_pending_active
`default_nettype wire

// >>> tb/src_model.sv
// far-side model: peripheral request lines
`timescale 1ns/1ps
`default_nettype none
module src_model (
	input wire logic ref_clk,
	input wire logic [16:0] fire,
	output logic [16:0] src
);
	// ====
	// requests are levels held until dropped
	always_ff @(posedge ref_clk) begin
		src <= fire;
	end
endmodule // src_model
`default_nettype wire

// >>> tb/irq_props.sv
// port assertions of the pending/active block
`timescale 1ns/1ps
`include "irq_regs_consts.vh"
`default_nettype none
module irq_props (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [31:0] rdata,
	input wire logic timer_one_src,
	input wire logic ext_pin_a_src,
	input wire logic debug_src,
	input wire logic [16:0] pending_out,
	input wire logic [16:0] active_out
);
	// ====
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	wire logic src_reg_rd = addr == `PENDING_SET_ADDR || addr == `PENDING_CLEAR_ADDR || addr == `ACTIVE_STATUS_ADDR;
	idle_read_zero_a: assert property (!rd_stb |=> rdata == 32'h0) else $error("rdata not zero");
	unmapped_zero_a: assert property (rd_stb && addr[31:12] != 20'he000e |=> rdata == 32'h0)
		else $error("unmapped");
	upper_bits_a: assert property (rd_stb && src_reg_rd |=> rdata[31:17] == 15'h0) else $error("upper bits");
	pend_set_a: assert property (wr_stb && addr == `PENDING_SET_ADDR |->
		##2 (pending_out & $past(wdata[16:0], 2)) == $past(wdata[16:0], 2)) else $error("pend set lost");
	pend_clear_a: assert property (wr_stb && addr == `PENDING_CLEAR_ADDR |->
		##2 (pending_out & $past(wdata[16:0], 2)) == 17'h0) else $error("pend clear lost");
	reset_zero_a: assert property ($rose(resetn) |-> pending_out == 17'h0 && active_out == 17'h0 && rdata == 32'h0)
		else $error("not cleared by reset");
	debug_bit_a: assert property ($rose(debug_src) |-> ##[1:4] (pending_out[16] || active_out[16]))
		else $error("debug");
	pin_a_bit_a: assert property ($rose(ext_pin_a_src) |-> ##[1:4] (pending_out[12] || active_out[12]))
		else $error("pin a");
	timer_bit_a: assert property ($rose(timer_one_src) |-> ##[1:4] (pending_out[0] || active_out[0]))
		else $error("tim");
endmodule // irq_props
bind irq_pending_active irq_props props_u (.ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
	.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .timer_one_src(timer_one_src), .ext_pin_a_src(ext_pin_a_src),
	.debug_src(debug_src), .pending_out(pending_out), .active_out(active_out));
`default_nettype wire

// >>> tb/irq_pending_active_tb.sv
// self-checking bench of the pending/active block
`timescale 1ns/1ps
`include "irq_regs_consts.vh"
`default_nettype none
module irq_pending_active_tb;
	logic ref_clk = 1'b0, resetn = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
	logic [31:0] addr = 32'h0, wdata = 32'h0;
	logic [16:0] fire = 17'h0, service_done = 17'h0, exp;
	wire logic [31:0] rdata;
	wire logic [16:0] s, pending_out, active_out;
	wire logic irq;
	int bad_count = 0, check_count = 0;
	src_model src_u (.ref_clk(ref_clk), .fire(fire), .src(s));
	irq_pending_active dut_u (.ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rdata(rdata), .timer_one_src(s[0]), .timer_two_src(s[1]), .management_src(s[2]),
		.baseband_src(s[3]), .sleep_timer_src(s[4]), .serial_ctrl_one_src(s[5]), .serial_ctrl_two_src(s[6]),
		.crypto_src(s[7]), .radio_timer_src(s[8]), .radio_tx_src(s[9]), .radio_rx_src(s[10]), .adc_src(s[11]),
		.ext_pin_a_src(s[12]), .ext_pin_b_src(s[13]), .ext_pin_c_src(s[14]), .ext_pin_d_src(s[15]),
		.debug_src(s[16]), .service_done(service_done), .pending_out(pending_out), .active_out(active_out), .irq(irq));
	// ====
	task automatic cmp(input string name, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		wr_stb <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] e, input string name);
		@(posedge ref_clk);
		rd_stb <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		#1 cmp(name, e, rdata);
	endtask
	// ====
	task automatic t_regs();
		exp = 17'h0;
		rd(`ACTIVE_STATUS_ADDR, 32'h0, "active reset");
		for (int i = 0; i < 17; i++) begin
			exp[i] = 1'b1;
			wr(`PENDING_SET_ADDR, 32'h1 << i);
			wr(`PENDING_SET_ADDR, 32'hfffe0000);
			rd(`PENDING_CLEAR_ADDR, {15'h0, exp}, "pend set");
		end
		wr(`ACTIVE_STATUS_ADDR, 32'hffffffff);
		rd(`ACTIVE_STATUS_ADDR, 32'h0, "active ro");
		rd(32'he000e0f0, 32'h0, "unmapped");
		for (int i = 0; i < 17; i++) begin
			exp[i] = 1'b0;
			wr(`PENDING_CLEAR_ADDR, 32'h1 << i);
			wr(`PENDING_CLEAR_ADDR, 32'h0);
			rd(`PENDING_SET_ADDR, {15'h0, exp}, "pend clear");
		end
	endtask
	task automatic t_src();
		for (int i = 0; i < 17; i++) begin
			fire <= 17'h1 << i;
			repeat (4) @(posedge ref_clk);
			rd(`PENDING_SET_ADDR, 32'h1 << i, "source map");
			wr(`PENDING_CLEAR_ADDR, 32'h1 << i);
		end
		cmp("irq masked", 32'h0, {31'h0, irq});
	endtask
	task automatic t_irq();
		wr(`IRQ_CLEAR_ADDR, 32'h3);
		wr(`IRQ_ENABLE_ADDR, 32'h1);
		fire <= 17'h20;
		repeat (4) @(posedge ref_clk);
		cmp("irq raised", 32'h1, {31'h0, irq});
		wr(`IRQ_CLEAR_ADDR, 32'h1);
		#1 cmp("irq cleared", 32'h0, {31'h0, irq});
		wr(`PENDING_CLEAR_ADDR, 32'h20);
		fire <= 17'h0;
	endtask
	task automatic t_act();
		wr(`PENDING_SET_ADDR, 32'h8);
		wr(`ENABLE_SET_ADDR, 32'h8);
		rd(`ENABLE_CLEAR_ADDR, 32'h8, "enable");
		repeat (3) @(posedge ref_clk);
		rd(`ACTIVE_STATUS_ADDR, 32'h8, "active");
		service_done <= 17'h8;
		@(posedge ref_clk);
		service_done <= 17'h0;
		repeat (2) @(posedge ref_clk);
		rd(`ACTIVE_STATUS_ADDR, 32'h0, "serviced");
		wr(`ENABLE_CLEAR_ADDR, 32'h8);
		rd(`ENABLE_SET_ADDR, 32'h0, "disable");
	endtask
	task automatic t_ack();
		wr(`IRQ_ENABLE_ADDR, 32'h2);
		rd(`IRQ_ENABLE_ADDR, 32'h2, "irq enable");
		wr(`ENABLE_SET_ADDR, 32'h3);
		wr(`PENDING_SET_ADDR, 32'h7);
		repeat (3) @(posedge ref_clk);
		#1 cmp("active out", 32'h3, {15'h0, active_out});
		cmp("pending out", 32'h4, {15'h0, pending_out});
		fire <= 17'h4;
		repeat (3) @(posedge ref_clk);
		#1 cmp("overrun irq", 32'h1, {31'h0, irq});
		rd(`IRQ_STATUS_ADDR, 32'h2, "irq status");
		wr(`IRQ_CLEAR_ADDR, 32'h2);
		#1 cmp("overrun cleared", 32'h0, {31'h0, irq});
		fire <= 17'h0;
		wr(`ACK_ADDR, 32'h3);
		rd(`ACTIVE_STATUS_ADDR, 32'h0, "ack");
		@(posedge ref_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		rd(`PENDING_SET_ADDR, 32'h0, "pend reset");
		rd(`ENABLE_SET_ADDR, 32'h0, "enable reset");
		rd(`IRQ_ENABLE_ADDR, 32'h0, "irq enable reset");
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ====
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		resetn <= 1'b1;
		t_regs();
		t_src();
		t_irq();
		t_act();
		t_ack();
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		complete_run();
	end
endmodule // irq_pending_active_tb
`default_nettype wire
